// >>> shared/dsb_cfg.svh
// offsets, field positions, reset values and widths of the status bank
`ifndef DSB_CFG_SVH
`define DSB_CFG_SVH

`define DSB_ADDR_W 8
`define DSB_OFF_OSC_TILE_CELL 8'h07
`define DSB_OFF_OSC_TILE_WIRE 8'h08
`define DSB_OFF_OSC_PERIPH_CELL 8'h09
`define DSB_OFF_OSC_PERIPH_WIRE 8'h0A
`define DSB_OFF_MEM_SIZE 8'h0C
`define DSB_OFF_SAVED_STATUS 8'h10
`define DSB_OFF_SAVED_PC 8'h11
`define DSB_OFF_SAVED_SP 8'h12
`define DSB_OFF_THREAD_SEL 8'h13
`define DSB_OFF_REG_SEL 8'h14
`define DSB_OFF_ENTRY_CAUSE 8'h15

`define DSB_OSC_W 16
`define DSB_NUM_OSC 4
`define DSB_MEM_LSB 2

`define DSB_SR_W 11
`define DSB_SR_EVENT_EN 0
`define DSB_SR_IRQ_EN 1
`define DSB_SR_IN_ENABLING 2
`define DSB_SR_IN_HANDLER 3
`define DSB_SR_KERNEL 4
`define DSB_SR_RSVD5 5
`define DSB_SR_PAUSED 6
`define DSB_SR_CONTINUAL 7
`define DSB_SR_DUAL_ISSUE 8
`define DSB_SR_ENTRY_ISSUE 9
`define DSB_SR_ADDR_SPACE 10

`define DSB_THREAD_W 8
`define DSB_TREG_W 5
`define DSB_CAUSE_CODE_LSB 0
`define DSB_CAUSE_CODE_MSB 2
`define DSB_CAUSE_THREAD_LSB 8
`define DSB_CAUSE_THREAD_MSB 15
`define DSB_CAUSE_INDEX_LSB 16
`define DSB_CAUSE_INDEX_MSB 17
`define DSB_NUM_POINTS 4

`define DSB_RST_WORD 32'h0000_0000
`define DSB_RST_CAUSE 3'h0
`define DSB_OSC_SYNC_STAGES 2

`endif

// >>> shared/dsb_pkg.sv
// types shared by the debug state and status bank
package dsb_pkg;
    typedef enum logic [2:0] {
        DSB_CAUSE_NONE = 3'h0,
        DSB_CAUSE_HOST = 3'h1,
        DSB_CAUSE_DBG_CALL = 3'h2,
        DSB_CAUSE_IBREAK = 3'h3,
        DSB_CAUSE_DWATCH = 3'h4,
        DSB_CAUSE_RWATCH = 3'h5
    } dsb_cause_t;

    typedef logic [1:0] dsb_point_idx_t;
endpackage

// >>> core/dsb_osc_counter.sv
// one ring oscillator counter with its enable and read-back crossings
`include "dsb_cfg.svh"

module dsb_osc_counter #(
    parameter int WIDTH = `DSB_OSC_W
) (
    input wire logic osc_clk_i,
    input wire logic por_i,
    input wire logic sys_clk_i,
    input wire logic enable_i,
    output logic [WIDTH-1:0] count_sys_o
);
    logic en_meta;
    logic en_sync;
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic [WIDTH-1:0] rd_meta;

    // wraps from all ones to zero
    always_comb begin
        next_count = count;
        if (en_sync) begin
            next_count = count + WIDTH'(1);
        end
    end

    // oscillator domain: cleared by power-up only
    always_ff @(posedge osc_clk_i or posedge por_i) begin
        if (por_i) begin
            en_meta <= 1'b0;
            en_sync <= 1'b0;
            count <= '0;
        end else begin
            en_meta <= enable_i;
            en_sync <= en_meta;
            count <= next_count;
        end
    end

    // value is stable once counting is disabled through en_sync, so a plain resync
    always_ff @(posedge sys_clk_i or posedge por_i) begin
        if (por_i) begin
            rd_meta <= '0;
            count_sys_o <= '0;
        end else begin
            rd_meta <= count;
            count_sys_o <= rd_meta;
        end
    end
endmodule

// >>> core/dsb_cause_encode.sv
// encodes the reason for a debug entry into the cause register fields
`include "dsb_cfg.svh"

module dsb_cause_encode #(
    parameter int NUM_POINTS = `DSB_NUM_POINTS
) (
    input wire logic host_req_i,
    input wire logic dbg_call_i,
    input wire logic [NUM_POINTS-1:0] ibreak_hit_i,
    input wire logic [NUM_POINTS-1:0] dwatch_hit_i,
    input wire logic [NUM_POINTS-1:0] rwatch_hit_i,
    input wire logic [`DSB_THREAD_W-1:0] thread_i,
    output dsb_pkg::dsb_cause_t code_o,
    output dsb_pkg::dsb_point_idx_t index_o,
    output logic [`DSB_THREAD_W-1:0] thread_o
);
    logic [NUM_POINTS-1:0] hits;

    function automatic dsb_pkg::dsb_point_idx_t lowest(
        input logic [NUM_POINTS-1:0] v
    );
        dsb_pkg::dsb_point_idx_t r;
        r = '0;
        for (int i = NUM_POINTS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = dsb_pkg::dsb_point_idx_t'(i);
            end
        end
        return r;
    endfunction

    always_comb begin
        code_o = dsb_pkg::DSB_CAUSE_NONE;
        hits = '0;
        if (host_req_i) begin
            code_o = dsb_pkg::DSB_CAUSE_HOST;
        end else if (dbg_call_i) begin
            code_o = dsb_pkg::DSB_CAUSE_DBG_CALL;
        end else if (|ibreak_hit_i) begin
            code_o = dsb_pkg::DSB_CAUSE_IBREAK;
            hits = ibreak_hit_i;
        end else if (|dwatch_hit_i) begin
            code_o = dsb_pkg::DSB_CAUSE_DWATCH;
            hits = dwatch_hit_i;
        end else if (|rwatch_hit_i) begin
            code_o = dsb_pkg::DSB_CAUSE_RWATCH;
            hits = rwatch_hit_i;
        end
        // zero index for host and debug-call entries
        index_o = lowest(hits);
        // thread is zero for host entries
        thread_o = host_req_i ? '0 : thread_i;
    end
endmodule

// >>> core/dsb_status_bank.sv
// processor status register bank: oscillator counts, ram size, debug state
// Summary of operation
// - four oscillator counts read in bits 15:0, bits 31:16 read zero.
// - oscillator counts survive system reset; only power-up clears them.
// - counters at 0x07..0x0A: tile cell, tile wire, periph cell, wire.
// - memory size register reports on-chip ram size in bytes.
// - size sits in read-only bits 31:2, bits 1:0 read zero.
// - debug entry captures the thread's status word with bit 5 cleared.
// - debug entry captures saved pc and saved stack pointer, 32 bits each.
// - status bit 7 continual issue, 6 paused waiting, 4 kernel mode.
// - bit 3 in handler, 2 enabling sequence, 1 irq enable, 0 events.
// - bit 8 read-only dual issue, 9 entry issue mode, 10 address space.
// - cause code is three bits wide and resets to zero.
// - cause 1 host, 2 debug call, 3 ibreak, 4 dwatch, 5 rwatch.
// - bits 17:16 hold point index, zero for host and debug call.
// - simultaneous hits record the lowest-numbered point.
// - bits 15:8 hold causing thread, zero for host entries.
// - each counter runs on its own free-running oscillator clock.
`include "dsb_cfg.svh"

module dsb_status_bank #(
    parameter int RAM_BYTES = 131072,
    parameter int NUM_POINTS = `DSB_NUM_POINTS
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic [`DSB_NUM_OSC-1:0] osc_clk_i,
    input wire logic osc_core_en_i,
    input wire logic osc_periph_en_i,
    input wire logic ps_rd_i,
    input wire logic ps_wr_i,
    input wire logic [`DSB_ADDR_W-1:0] ps_addr_i,
    input wire logic [31:0] ps_wdata_i,
    input wire logic debug_mode_i,
    input wire logic dbg_entry_i,
    input wire logic [`DSB_SR_W-1:0] thread_status_i,
    input wire logic [31:0] thread_pc_i,
    input wire logic [31:0] thread_sp_i,
    input wire logic [`DSB_THREAD_W-1:0] entry_thread_i,
    input wire logic host_req_i,
    input wire logic dbg_call_i,
    input wire logic [NUM_POINTS-1:0] ibreak_hit_i,
    input wire logic [NUM_POINTS-1:0] dwatch_hit_i,
    input wire logic [NUM_POINTS-1:0] rwatch_hit_i,
    output logic [31:0] ps_rdata_o,
    output logic ps_rvalid_o,
    output logic [`DSB_THREAD_W-1:0] target_thread_index_o,
    output logic [`DSB_TREG_W-1:0] target_register_index_o
);
    localparam logic [31:0] MEM_SIZE_WORD = 32'(RAM_BYTES);
    localparam logic [`DSB_SR_W-1:0] SR_WMASK =
        ~((`DSB_SR_W'(1) << `DSB_SR_DUAL_ISSUE) |
          (`DSB_SR_W'(1) << `DSB_SR_RSVD5));

    logic [`DSB_OSC_W-1:0] osc_count [`DSB_NUM_OSC];
    logic [`DSB_NUM_OSC-1:0] osc_en;

    logic [`DSB_SR_W-1:0] saved_status_word;
    logic [31:0] saved_program_counter;
    logic [31:0] saved_stack_pointer;
    logic [`DSB_THREAD_W-1:0] target_thread_index;
    logic [`DSB_TREG_W-1:0] target_register_index;
    logic [2:0] debug_cause_code;
    logic [`DSB_THREAD_W-1:0] causing_thread_index;
    dsb_pkg::dsb_point_idx_t point_index;

    logic [`DSB_SR_W-1:0] next_saved_status_word;
    logic [31:0] next_saved_program_counter;
    logic [31:0] next_saved_stack_pointer;
    logic [`DSB_THREAD_W-1:0] next_target_thread_index;
    logic [`DSB_TREG_W-1:0] next_target_register_index;
    logic [2:0] next_debug_cause_code;
    logic [`DSB_THREAD_W-1:0] next_causing_thread_index;
    dsb_pkg::dsb_point_idx_t next_point_index;
    logic [31:0] next_ps_rdata;
    logic next_ps_rvalid;

    dsb_pkg::dsb_cause_t enc_code;
    dsb_pkg::dsb_point_idx_t enc_index;
    logic [`DSB_THREAD_W-1:0] enc_thread;
    logic dbg_wr;

    // core enable drives the tile pair, periph enable the periph pair
    assign osc_en = {osc_periph_en_i, osc_periph_en_i,
                     osc_core_en_i, osc_core_en_i};

    for (genvar g = 0; g < `DSB_NUM_OSC; g++) begin : g_osc
        dsb_osc_counter #(
            .WIDTH(`DSB_OSC_W)
        ) u_osc (
            .osc_clk_i(osc_clk_i[g]),
            .por_i(por_i),
            .sys_clk_i(sys_clk_i),
            .enable_i(osc_en[g]),
            .count_sys_o(osc_count[g])
        );
    end

    dsb_cause_encode #(
        .NUM_POINTS(NUM_POINTS)
    ) u_cause (
        .host_req_i(host_req_i),
        .dbg_call_i(dbg_call_i),
        .ibreak_hit_i(ibreak_hit_i),
        .dwatch_hit_i(dwatch_hit_i),
        .rwatch_hit_i(rwatch_hit_i),
        .thread_i(entry_thread_i),
        .code_o(enc_code),
        .index_o(enc_index),
        .thread_o(enc_thread)
    );

    assign dbg_wr = ps_wr_i && debug_mode_i;

    // debug state: a debug entry in the same cycle beats a write to saved status, pc, sp or cause
    always_comb begin
        next_saved_status_word = saved_status_word;
        next_saved_program_counter = saved_program_counter;
        next_saved_stack_pointer = saved_stack_pointer;
        next_target_thread_index = target_thread_index;
        next_target_register_index = target_register_index;
        next_debug_cause_code = debug_cause_code;
        next_causing_thread_index = causing_thread_index;
        next_point_index = point_index;
        if (dbg_wr) begin
            unique case (ps_addr_i)
                `DSB_OFF_SAVED_STATUS: begin
                    // dual-issue bit and bit 5 stay as captured
                    next_saved_status_word =
                        (saved_status_word & ~SR_WMASK) |
                        (ps_wdata_i[`DSB_SR_W-1:0] & SR_WMASK);
                end
                `DSB_OFF_SAVED_PC: begin
                    next_saved_program_counter = ps_wdata_i;
                end
                `DSB_OFF_SAVED_SP: begin
                    next_saved_stack_pointer = ps_wdata_i;
                end
                `DSB_OFF_THREAD_SEL: begin
                    next_target_thread_index =
                        ps_wdata_i[`DSB_THREAD_W-1:0];
                end
                `DSB_OFF_REG_SEL: begin
                    next_target_register_index =
                        ps_wdata_i[`DSB_TREG_W-1:0];
                end
                `DSB_OFF_ENTRY_CAUSE: begin
                    next_debug_cause_code = ps_wdata_i[
                        `DSB_CAUSE_CODE_MSB:`DSB_CAUSE_CODE_LSB];
                    next_causing_thread_index = ps_wdata_i[
                        `DSB_CAUSE_THREAD_MSB:`DSB_CAUSE_THREAD_LSB];
                    next_point_index = ps_wdata_i[
                        `DSB_CAUSE_INDEX_MSB:`DSB_CAUSE_INDEX_LSB];
                end
                default: begin
                end
            endcase
        end
        if (dbg_entry_i) begin
            next_saved_status_word = thread_status_i;
            next_saved_status_word[`DSB_SR_RSVD5] = 1'b0;
            next_saved_program_counter = thread_pc_i;
            next_saved_stack_pointer = thread_sp_i;
            next_debug_cause_code = 3'(enc_code);
            next_causing_thread_index = enc_thread;
            next_point_index = enc_index;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            saved_status_word <= `DSB_SR_W'(`DSB_RST_WORD);
            saved_program_counter <= `DSB_RST_WORD;
            saved_stack_pointer <= `DSB_RST_WORD;
            target_thread_index <= `DSB_THREAD_W'(`DSB_RST_WORD);
            target_register_index <= `DSB_TREG_W'(`DSB_RST_WORD);
            debug_cause_code <= `DSB_RST_CAUSE;
            causing_thread_index <= `DSB_THREAD_W'(`DSB_RST_WORD);
            point_index <= '0;
            target_thread_index_o <= '0;
            target_register_index_o <= '0;
        end else begin
            saved_status_word <= next_saved_status_word;
            saved_program_counter <= next_saved_program_counter;
            saved_stack_pointer <= next_saved_stack_pointer;
            target_thread_index <= next_target_thread_index;
            target_register_index <= next_target_register_index;
            debug_cause_code <= next_debug_cause_code;
            causing_thread_index <= next_causing_thread_index;
            point_index <= next_point_index;
            target_thread_index_o <= next_target_thread_index;
            target_register_index_o <= next_target_register_index;
        end
    end

    // read path: answer one cycle after the read strobe
    always_comb begin
        next_ps_rdata = '0;
        next_ps_rvalid = ps_rd_i;
        if (ps_rd_i) begin
            unique case (ps_addr_i)
                `DSB_OFF_OSC_TILE_CELL: begin
                    next_ps_rdata[`DSB_OSC_W-1:0] = osc_count[0];
                end
                `DSB_OFF_OSC_TILE_WIRE: begin
                    next_ps_rdata[`DSB_OSC_W-1:0] = osc_count[1];
                end
                `DSB_OFF_OSC_PERIPH_CELL: begin
                    next_ps_rdata[`DSB_OSC_W-1:0] = osc_count[2];
                end
                `DSB_OFF_OSC_PERIPH_WIRE: begin
                    next_ps_rdata[`DSB_OSC_W-1:0] = osc_count[3];
                end
                `DSB_OFF_MEM_SIZE: begin
                    next_ps_rdata[31:`DSB_MEM_LSB] =
                        MEM_SIZE_WORD[31:`DSB_MEM_LSB];
                end
                `DSB_OFF_SAVED_STATUS: begin
                    next_ps_rdata[`DSB_SR_W-1:0] =
                        saved_status_word;
                end
                `DSB_OFF_SAVED_PC: begin
                    next_ps_rdata = saved_program_counter;
                end
                `DSB_OFF_SAVED_SP: begin
                    next_ps_rdata = saved_stack_pointer;
                end
                `DSB_OFF_THREAD_SEL: begin
                    next_ps_rdata[`DSB_THREAD_W-1:0] = target_thread_index;
                end
                `DSB_OFF_REG_SEL: begin
                    next_ps_rdata[`DSB_TREG_W-1:0] = target_register_index;
                end
                `DSB_OFF_ENTRY_CAUSE: begin
                    next_ps_rdata[`DSB_CAUSE_CODE_MSB:`DSB_CAUSE_CODE_LSB] =
                        debug_cause_code;
                    next_ps_rdata[`DSB_CAUSE_THREAD_MSB:
                                  `DSB_CAUSE_THREAD_LSB] =
                        causing_thread_index;
                    next_ps_rdata[`DSB_CAUSE_INDEX_MSB:`DSB_CAUSE_INDEX_LSB] =
                        point_index;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ps_rdata_o <= '0;
            ps_rvalid_o <= 1'b0;
        end else begin
            ps_rdata_o <= next_ps_rdata;
            ps_rvalid_o <= next_ps_rvalid;
        end
    end
endmodule

// >>> test/dsb_status_bank_monitor.sv
// concurrent checks on the ports of the status bank
`include "dsb_cfg.svh"

module dsb_status_bank_monitor #(
    parameter int RAM_BYTES = 131072,
    parameter int NUM_POINTS = `DSB_NUM_POINTS
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ps_rd_i,
    input wire logic ps_wr_i,
    input wire logic [`DSB_ADDR_W-1:0] ps_addr_i,
    input wire logic [31:0] ps_wdata_i,
    input wire logic debug_mode_i,
    input wire logic dbg_entry_i,
    input wire logic host_req_i,
    input wire logic [31:0] thread_pc_i,
    input wire logic [31:0] ps_rdata_o,
    input wire logic ps_rvalid_o,
    input wire logic [`DSB_THREAD_W-1:0] target_thread_index_o,
    input wire logic [`DSB_TREG_W-1:0] target_register_index_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] MEM_WORD = 32'(RAM_BYTES) & 32'hFFFF_FFFC;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence rd_at(a);
        ps_rd_i && ps_addr_i == a;
    endsequence

    AST_RVALID_PULSE: assert property (ps_rd_i |=> ps_rvalid_o)
        else $error("read not answered one cycle later");
    AST_IDLE_QUIET: assert property (!ps_rd_i |=>
        !ps_rvalid_o && ps_rdata_o == 32'h0000_0000)
        else $error("read data or valid without a read");
    AST_OSC_UPPER: assert property ((ps_rd_i &&
        ps_addr_i >= 8'h07 && ps_addr_i <= 8'h0A) |=>
        ps_rdata_o[31:16] == 16'h0000)
        else $error("counter upper half not zero");
    AST_MEM_SIZE: assert property (rd_at(8'h0C) |=>
        ps_rdata_o == MEM_WORD)
        else $error("memory size word wrong");
    AST_STATUS_RSVD: assert property (rd_at(8'h10) |=>
        ps_rdata_o[31:11] == 21'h0 && ps_rdata_o[5] == 1'b0)
        else $error("saved status reserved bits set");
    AST_CAUSE_RSVD: assert property (rd_at(8'h15) |=>
        ps_rdata_o[31:18] == 14'h0 && ps_rdata_o[7:3] == 5'h0)
        else $error("cause reserved bits set");
    AST_SEL_WRITE: assert property (ps_wr_i && debug_mode_i &&
        ps_addr_i == 8'h13 |=> target_thread_index_o == $past(ps_wdata_i[7:0]))
        else $error("thread select not written");
    AST_REG_WRITE: assert property (ps_wr_i && debug_mode_i &&
        ps_addr_i == 8'h14 |=>
        target_register_index_o == $past(ps_wdata_i[4:0]))
        else $error("register select not written");
    AST_WRITE_REFUSED: assert property (ps_wr_i && !debug_mode_i
        |=> $stable(target_thread_index_o) && $stable(target_register_index_o))
        else $error("write accepted outside debug mode");
    AST_HOST_CAUSE: assert property (dbg_entry_i && host_req_i ##1
        rd_at(8'h15) |=> ps_rdata_o[17:0] == 18'h00001)
        else $error("host entry cause fields wrong");
    AST_PC_CAPTURE: assert property (dbg_entry_i ##1 rd_at(8'h11)
        |=> ps_rdata_o == $past(thread_pc_i, 2))
        else $error("saved pc not captured");

    cover property (dbg_entry_i && host_req_i);
    cover property (ps_wr_i && !debug_mode_i);
    cover property (dbg_entry_i && ps_wr_i);
endmodule

bind dsb_status_bank dsb_status_bank_monitor #(.RAM_BYTES(RAM_BYTES),
    .NUM_POINTS(NUM_POINTS)) dsb_status_bank_monitor_i (.sys_clk_i, .rst_i,
    .ps_rd_i, .ps_wr_i, .ps_addr_i, .ps_wdata_i, .debug_mode_i, .dbg_entry_i,
    .host_req_i, .thread_pc_i, .ps_rdata_o, .ps_rvalid_o,
    .target_thread_index_o, .target_register_index_o);

// >>> test/dsb_osc_model.sv
// free-running ring oscillator sources beside the status bank
module dsb_osc_model (
    output logic [3:0] osc_clk_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial osc_clk_o = 4'h0;
    // periods unrelated to the core clock, cell faster than wire
    always #3.5 osc_clk_o[0] = ~osc_clk_o[0];
    always #4.5 osc_clk_o[1] = ~osc_clk_o[1];
    always #5.5 osc_clk_o[2] = ~osc_clk_o[2];
    always #6.5 osc_clk_o[3] = ~osc_clk_o[3];
endmodule

// >>> test/debug_state_status_bank_tb.sv
// self-checking bench for the status bank
module debug_state_status_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MEM = 32'h0001_2346;
    logic sys_clk_i, rst_i, por_i, osc_core_en_i, osc_periph_en_i;
    logic ps_rd_i, ps_wr_i, debug_mode_i, dbg_entry_i, host_req_i, dbg_call_i;
    logic ps_rvalid_o;
    logic [3:0] osc_clk_i, ibreak_hit_i, dwatch_hit_i, rwatch_hit_i;
    logic [7:0] ps_addr_i, entry_thread_i, target_thread_index_o;
    logic [4:0] target_register_index_o;
    logic [10:0] thread_status_i;
    logic [31:0] ps_wdata_i, thread_pc_i, thread_sp_i, ps_rdata_o, d, w;
    logic [31:0] cnt [4];
    logic [13:0] src;
    logic [13:0] corner [5] = '{14'h2500, 14'h1C00, 14'h0AF0, 14'h0081,
        14'h0006};
    int err_total, checked;

    dsb_osc_model dsb_osc_model_i (.osc_clk_o(osc_clk_i));
    dsb_status_bank #(.RAM_BYTES(MEM)) dsb_status_bank_i (.sys_clk_i, .rst_i,
        .por_i, .osc_clk_i, .osc_core_en_i, .osc_periph_en_i, .ps_rd_i,
        .ps_wr_i, .ps_addr_i, .ps_wdata_i, .debug_mode_i, .dbg_entry_i,
        .thread_status_i, .thread_pc_i, .thread_sp_i, .entry_thread_i,
        .host_req_i, .dbg_call_i, .ibreak_hit_i, .dwatch_hit_i, .rwatch_hit_i,
        .ps_rdata_o, .ps_rvalid_o, .target_thread_index_o,
        .target_register_index_o);

    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    task automatic cmp(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        if (err_total == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // all bus tasks start and end at a falling edge
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        ps_rd_i = 1'b1;
        ps_addr_i = a;
        @(negedge sys_clk_i);
        q = ps_rdata_o;
        ps_rd_i = 1'b0;
        @(negedge sys_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        ps_wr_i = 1'b1;
        ps_addr_i = a;
        ps_wdata_i = v;
        @(negedge sys_clk_i);
        ps_wr_i = 1'b0;
        @(negedge sys_clk_i);
    endtask

    task automatic entry(input logic [13:0] s);
        {host_req_i, dbg_call_i, ibreak_hit_i, dwatch_hit_i, rwatch_hit_i} = s;
        thread_status_i = 11'($urandom);
        thread_pc_i = $urandom;
        thread_sp_i = $urandom;
        entry_thread_i = 8'($urandom);
        dbg_entry_i = 1'b1;
        @(negedge sys_clk_i);
        dbg_entry_i = 1'b0;
        ps_wr_i = 1'b0;
    endtask

    function automatic logic [1:0] low(input logic [3:0] v);
        low = 2'h0;
        for (int k = 3; k >= 0; k--)
            if (v[k]) low = 2'(k);
    endfunction

    function automatic logic [31:0] exp_cause();
        logic [2:0] c;
        logic [1:0] x;
        logic [7:0] t;
        c = 3'h0;
        x = 2'h0;
        t = entry_thread_i;
        if (host_req_i) begin
            c = 3'h1;
            t = 8'h00;
        end else if (dbg_call_i) c = 3'h2;
        else if (|ibreak_hit_i) begin
            c = 3'h3;
            x = low(ibreak_hit_i);
        end else if (|dwatch_hit_i) begin
            c = 3'h4;
            x = low(dwatch_hit_i);
        end else if (|rwatch_hit_i) begin
            c = 3'h5;
            x = low(rwatch_hit_i);
        end
        return {14'h0, x, t, 5'h0, c};
    endfunction

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        err_total++;
        conclude();
    end

    initial begin
        {rst_i, por_i} = 2'b11;
        {osc_core_en_i, osc_periph_en_i, ps_rd_i, ps_wr_i} = 4'h0;
        {debug_mode_i, dbg_entry_i} = 2'b00;
        ps_addr_i = 8'h00;
        ps_wdata_i = 32'h0000_0000;
        void'($urandom(76));
        // entry spends the first of the two reset cycles
        entry(14'h0000);
        @(negedge sys_clk_i);
        {rst_i, por_i} = 2'b00;
        for (int a = 16; a < 22; a++) begin
            rd(8'(a), d);
            cmp("reset value", 32'h0000_0000, d);
        end
        rd(8'h0B, d);
        cmp("unmapped read", 32'h0000_0000, d);
        rd(8'h0C, d);
        cmp("memory size", MEM & 32'hFFFF_FFFC, d);
        osc_core_en_i = 1'b1;
        repeat (40) @(negedge sys_clk_i);
        osc_core_en_i = 1'b0;
        repeat (12) @(negedge sys_clk_i);
        for (int k = 0; k < 4; k++) rd(8'h07 + 8'(k), cnt[k]);
        cmp("periph counters idle", 32'h0, cnt[2] | cnt[3]);
        cmp("tile cell ahead", 32'h1, {31'h0, cnt[0] > cnt[1]});
        osc_periph_en_i = 1'b1;
        repeat (40) @(negedge sys_clk_i);
        osc_periph_en_i = 1'b0;
        repeat (12) @(negedge sys_clk_i);
        for (int k = 2; k < 4; k++) rd(8'h07 + 8'(k), cnt[k]);
        cmp("periph cell ahead", 32'h1, {31'h0, cnt[2] > cnt[3]});
        debug_mode_i = 1'b1;
        wr(8'h07, 32'hFFFF_FFFF);
        rst_i = 1'b1;
        @(negedge sys_clk_i);
        rst_i = 1'b0;
        for (int k = 0; k < 4; k++) begin
            rd(8'h07 + 8'(k), d);
            cmp("counter kept", cnt[k] & 32'h0000_FFFF, d);
        end
        for (int k = 0; k < 6; k++) begin
            w = $urandom;
            wr(8'h13, w);
            wr(8'h14, ~w);
            cmp("thread select", {24'h0, w[7:0]},
                32'(target_thread_index_o));
            cmp("reg select", {27'h0, ~w[4:0]},
                32'(target_register_index_o));
            rd(8'h14, d);
            cmp("reg select word", {27'h0, ~w[4:0]}, d);
            debug_mode_i = 1'b0;
            wr(8'h13, ~w);
            cmp("locked select", {24'h0, w[7:0]},
                32'(target_thread_index_o));
            debug_mode_i = 1'b1;
        end
        for (int i = 0; i < 24; i++) begin
            src = (i < 5) ? corner[i] : 14'($urandom);
            if (src == 14'h0) src = 14'h0001;
            entry(src);
            rd(8'h15, d);
            cmp("entry cause", exp_cause(), d);
            rd(8'h11, d);
            cmp("saved pc", thread_pc_i, d);
            rd(8'h12, d);
            cmp("saved sp", thread_sp_i, d);
            rd(8'h10, d);
            cmp("saved status", {21'h0, thread_status_i & 11'h7DF},
                d);
        end
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10, d);
        cmp("status write",
            {21'h0, 2'b11, thread_status_i[8], 8'hDF}, d);
        wr(8'h12, w);
        rd(8'h12, d);
        cmp("saved sp write", w, d);
        wr(8'h15, w);
        rd(8'h15, d);
        cmp("cause write", w & 32'h0003_FF07, d);
        ps_wr_i = 1'b1;
        ps_addr_i = 8'h11;
        ps_wdata_i = 32'h5A5A_5A5A;
        entry(14'h2000);
        rd(8'h11, d);
        cmp("entry beats write", thread_pc_i, d);
        conclude();
    end
endmodule
